/* pkg/file_port_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface file_port_if;
    import move_exec_pkg::*;
    logic [AddrWidth-1:0] rdAddr;
    logic [DataWidth-1:0] rdData;
    logic wrEn;
    logic [AddrWidth-1:0] wrAddr;
    logic [DataWidth-1:0] wrData;
    modport core (output rdAddr, input rdData, output wrEn, output wrAddr, output wrData);
    modport store (input rdAddr, output rdData, input wrEn, input wrAddr, input wrData);
endinterface
`default_nettype wire

/* pkg/move_exec_pkg.sv */
// Operation
// - store work copies W into file, zero flag kept
// - file move goes to W or back
// - file move sets zero flag from value
// - literal load puts immediate in W
// - config load copies W to config register
`default_nettype none
package move_exec_pkg;
    localparam int DataWidth = 8;
    localparam int AddrWidth = 5;
    localparam int InstrWidth = 12;
    localparam logic [DataWidth-1:0] WorkReset = 8'h00;
    localparam logic [DataWidth-1:0] ConfigReset = 8'hFF;
    localparam logic [DataWidth-1:0] FileReset = 8'h00;
    localparam logic [InstrWidth-1:0] OpIdle = 12'h000;
    localparam logic [InstrWidth-1:0] OpConfig = 12'h002;
    localparam logic [InstrWidth-1:0] MaskStore = 12'hFE0;
    localparam logic [InstrWidth-1:0] OpStore = 12'h020;
    localparam logic [InstrWidth-1:0] MaskMove = 12'hFC0;
    localparam logic [InstrWidth-1:0] OpMove = 12'h200;
    localparam logic [InstrWidth-1:0] MaskLit = 12'hF00;
    localparam logic [InstrWidth-1:0] OpLit = 12'hC00;
    localparam int DestBit = 5;
    typedef enum logic [2:0] {
        instrIdle, instrStore, instrMove, instrLit, instrConfig, instrOther
    } instr_kind_t;
endpackage
`default_nettype wire

/* rtl/file_store.sv */
`timescale 1ns/1ps
`default_nettype none
module file_store
    import move_exec_pkg::*;
#(
    parameter int Depth = 32
) (
    input wire logic clk,
    input wire logic rstn,
    file_port_if.store port
);
    typedef struct packed {
        logic [Depth-1:0][DataWidth-1:0] mem;
    } store_state_t;
    store_state_t s_q, s_d;
    if (Depth > (1 << AddrWidth) || Depth < 1) begin : g_bad_depth
        $error("file_store depth out of range");
    end
    assign port.rdData = (int'(port.rdAddr) < Depth) ? s_q.mem[port.rdAddr] : FileReset;
    always_comb begin
        s_d = s_q;
        if (port.wrEn && int'(port.wrAddr) < Depth) begin
            s_d.mem[port.wrAddr] = port.wrData;
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q.mem <= {Depth{FileReset}};
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

/* rtl/move_and_config_load_execute.sv */
`timescale 1ns/1ps
`default_nettype none
module move_and_config_load_execute
    import move_exec_pkg::*;
#(
    parameter int FileDepth = 1 << AddrWidth
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic instrValid,
    input wire logic [InstrWidth-1:0] instr,
    input wire logic [AddrWidth-1:0] dbgAddr,
    output logic [DataWidth-1:0] dbgData,
    output logic [DataWidth-1:0] workReg,
    output logic [DataWidth-1:0] configReg,
    output logic zeroFlag,
    output logic illegalInstr
);
    typedef struct packed {
        logic [DataWidth-1:0] work;
        logic [DataWidth-1:0] cfg;
        logic zero;
        logic illegal;
        logic [DataWidth-1:0] dbg;
    } core_state_t;
    core_state_t s_q, s_d;
    instr_kind_t kind;
    logic [AddrWidth-1:0] fAddr;
    logic destFile;
    // the address field cannot reach more cells than this
    if (FileDepth < 1 || FileDepth > (1 << AddrWidth)) begin : g_bad_depth
        $error("file depth out of range");
    end
    // destination bit must sit above the address field
    if (DestBit < AddrWidth || DestBit >= InstrWidth) begin : g_bad_dest
        $error("destination bit overlaps the address field");
    end
    if (DataWidth > InstrWidth) begin : g_bad_literal
        $error("literal field wider than the instruction");
    end
    file_port_if fp ();
    file_store #(.Depth(FileDepth)) uStore (
        .clk(clk),
        .rstn(rstn),
        .port(fp)
    );
    assign fAddr = instr[AddrWidth-1:0];
    assign destFile = instr[DestBit];
    always_comb begin
        if (instr == OpIdle) begin
            kind = instrIdle;
        end else if (instr == OpConfig) begin
            kind = instrConfig;
        end else if ((instr & MaskStore) == OpStore) begin
            kind = instrStore;
        end else if ((instr & MaskMove) == OpMove) begin
            kind = instrMove;
        end else if ((instr & MaskLit) == OpLit) begin
            kind = instrLit;
        end else begin
            kind = instrOther;
        end
    end
    // debug reads share the port only when no instruction uses it
    assign fp.rdAddr = (instrValid && kind == instrMove) ? fAddr : dbgAddr;
    always_comb begin
        s_d = s_q;
        fp.wrEn = 1'b0;
        fp.wrAddr = fAddr;
        fp.wrData = s_q.work;
        s_d.illegal = 1'b0;
        s_d.dbg = fp.rdData;
        if (instrValid) begin
            unique case (kind)
                instrIdle: begin
                end
                instrStore: begin
                    fp.wrEn = 1'b1;
                end
                instrMove: begin
                    if (destFile) begin
                        fp.wrEn = 1'b1;
                        fp.wrData = fp.rdData;
                    end else begin
                        s_d.work = fp.rdData;
                    end
                    s_d.zero = (fp.rdData == '0);
                end
                instrLit: begin
                    s_d.work = instr[DataWidth-1:0];
                end
                instrConfig: begin
                    s_d.cfg = s_q.work;
                end
                instrOther: begin
                    // outside this block: flag it, change nothing
                    s_d.illegal = 1'b1;
                end
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q.work <= WorkReset;
            s_q.cfg <= ConfigReset;
            s_q.zero <= 1'b0;
            s_q.illegal <= 1'b0;
            s_q.dbg <= FileReset;
        end else begin
            s_q <= s_d;
        end
    end
    assign workReg = s_q.work;
    assign configReg = s_q.cfg;
    assign zeroFlag = s_q.zero;
    assign illegalInstr = s_q.illegal;
    assign dbgData = s_q.dbg;

    a_store_flags: assert property (@(posedge clk) disable iff (!rstn)
        instrValid && kind == instrStore |=> zeroFlag == $past(zeroFlag)
            && workReg == $past(workReg))
        else $error("store changed flags or work");
    a_move_work: assert property (@(posedge clk) disable iff (!rstn)
        instrValid && kind == instrMove && !destFile |=> workReg == $past(fp.rdData))
        else $error("file move did not reach work");
    a_move_zero: assert property (@(posedge clk) disable iff (!rstn)
        instrValid && kind == instrMove |=> zeroFlag == ($past(fp.rdData) == '0))
        else $error("zero flag wrong after move");
    a_lit_load: assert property (@(posedge clk) disable iff (!rstn)
        instrValid && kind == instrLit |=> workReg == $past(instr[DataWidth-1:0])
            && $stable(zeroFlag))
        else $error("literal load wrong");
    a_cfg_load: assert property (@(posedge clk) disable iff (!rstn)
        instrValid && kind == instrConfig |=> configReg == $past(workReg)
            && $stable(zeroFlag))
        else $error("config load wrong");
    a_idle_quiet: assert property (@(posedge clk) disable iff (!rstn)
        (!instrValid || kind == instrIdle) |-> !fp.wrEn ##1
            ($stable(workReg) && $stable(configReg) && $stable(zeroFlag)))
        else $error("idle changed state");
    a_store_write: assert property (@(posedge clk) disable iff (!rstn)
        instrValid && kind == instrStore |-> fp.wrEn && fp.wrData == workReg)
        else $error("store did not write work");
    a_move_back: assert property (@(posedge clk) disable iff (!rstn)
        instrValid && kind == instrMove && destFile |=> $stable(workReg))
        else $error("move back touched work");

    // each path also checks what it must leave alone
    a_store_addr: assert property (@(posedge clk) disable iff (!rstn)
        instrValid && kind == instrStore
            |-> fp.wrAddr == fAddr)
        else $error("store wrote the wrong cell");

    a_store_config: assert property (@(posedge clk) disable iff (!rstn)
        instrValid && kind == instrStore
            |=> $stable(configReg) && !illegalInstr)
        else $error("store touched config");

    a_move_read: assert property (@(posedge clk) disable iff (!rstn)
        instrValid && kind == instrMove
            |-> fp.rdAddr == fAddr)
        else $error("move read the wrong cell");

    a_move_write: assert property (@(posedge clk) disable iff (!rstn)
        instrValid && kind == instrMove && destFile
            |-> fp.wrEn && fp.wrAddr == fAddr && fp.wrData == fp.rdData)
        else $error("move back did not rewrite the cell");

    a_move_to_work: assert property (@(posedge clk) disable iff (!rstn)
        instrValid && kind == instrMove && !destFile
            |-> !fp.wrEn)
        else $error("move to work wrote a cell");

    a_move_config: assert property (@(posedge clk) disable iff (!rstn)
        instrValid && kind == instrMove
            |=> $stable(configReg))
        else $error("move touched config");

    a_zero_only_move: assert property (@(posedge clk) disable iff (!rstn)
        !(instrValid && kind == instrMove)
            |=> $stable(zeroFlag))
        else $error("zero flag moved without a file move");

    a_lit_quiet: assert property (@(posedge clk) disable iff (!rstn)
        instrValid && kind == instrLit
            |-> !fp.wrEn ##1 $stable(configReg))
        else $error("literal load touched file or config");

    a_cfg_quiet: assert property (@(posedge clk) disable iff (!rstn)
        instrValid && kind == instrConfig
            |-> !fp.wrEn ##1 $stable(workReg))
        else $error("config load touched file or work");

    a_cfg_only_load: assert property (@(posedge clk) disable iff (!rstn)
        !(instrValid && kind == instrConfig)
            |=> $stable(configReg))
        else $error("config changed without a config load");

    a_work_only_load: assert property (@(posedge clk) disable iff (!rstn)
        !(instrValid && (kind == instrLit || (kind == instrMove && !destFile)))
            |=> $stable(workReg))
        else $error("work changed without a load");

    a_write_source: assert property (@(posedge clk) disable iff (!rstn)
        fp.wrEn
            |-> instrValid && (kind == instrStore || (kind == instrMove && destFile)))
        else $error("file written without a store or move back");

    a_other_quiet: assert property (@(posedge clk) disable iff (!rstn)
        instrValid && kind == instrOther
            |-> !fp.wrEn ##1 (illegalInstr && $stable(workReg)
            && $stable(configReg) && $stable(zeroFlag)))
        else $error("unhandled word changed state");

    a_illegal_pulse: assert property (@(posedge clk) disable iff (!rstn)
        !(instrValid && kind == instrOther)
            |=> !illegalInstr)
        else $error("illegal flag without an unhandled word");

    // back to back: the later word sees the earlier result
    a_back_to_back: assert property (@(posedge clk) disable iff (!rstn)
        (instrValid && kind == instrLit) ##1 (instrValid && kind == instrConfig)
            |=> configReg == $past(instr[DataWidth-1:0], 2))
        else $error("config load missed the literal just loaded");
endmodule
`default_nettype wire

/* sim/test_move_and_config_load_execute.sv */
`timescale 1ns/1ps
`default_nettype none
module test_move_and_config_load_execute;
    import move_exec_pkg::*;
    typedef struct packed {
        logic [7:0] work;
        logic [7:0] cfg;
        logic zero;
        logic ill;
        logic dbgOn;
        logic [7:0] dbg;
    } note_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic instrValid = 1'b0;
    logic [InstrWidth-1:0] instr = OpIdle;
    logic [AddrWidth-1:0] dbgAddr = 5'h00;
    logic [DataWidth-1:0] dbgData, workReg, configReg;
    logic zeroFlag, illegalInstr;
    logic [7:0] w = WorkReset;
    logic [7:0] cfg = ConfigReset;
    logic [7:0] mem [32];
    logic z = 1'b0;
    int error_cnt = 0;
    int samples_checked = 0;
    note_t notes[$];
    note_t n;
    always #2.5 clk = ~clk;
    move_and_config_load_execute i_move_and_config_load_execute (.clk(clk), .rstn(rstn),
        .instrValid(instrValid), .instr(instr), .dbgAddr(dbgAddr), .dbgData(dbgData),
        .workReg(workReg), .configReg(configReg), .zeroFlag(zeroFlag),
        .illegalInstr(illegalInstr));
    task automatic cmp(input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (e !== g) begin
            error_cnt++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_bit(input logic e, input logic g);
        samples_checked++;
        if (e !== g) begin
            error_cnt++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // model runs at drive time; the note is due one edge later
    task automatic issue(input logic [11:0] ins, input logic [4:0] a);
        logic [7:0] v;
        logic ill;
        @(negedge clk);
        instr = ins;
        dbgAddr = a;
        instrValid = 1'b1;
        v = mem[ins[4:0]];
        ill = 1'b0;
        if ((ins & MaskLit) == OpLit) w = ins[7:0];
        else if ((ins & MaskStore) == OpStore) mem[ins[4:0]] = w;
        else if ((ins & MaskMove) == OpMove) begin
            if (!ins[DestBit]) w = v;
            z = (v == 8'h00);
        end else if (ins == OpConfig) cfg = w;
        else if (ins != OpIdle) ill = 1'b1;
        notes.push_back('{w, cfg, z, ill, ins == OpIdle, mem[a]});
    endtask
    always @(posedge clk) begin
        #1;
        if (notes.size() > 0) begin
            n = notes.pop_front();
            cmp(n.work, workReg);
            cmp(n.cfg, configReg);
            cmp_bit(n.zero, zeroFlag);
            cmp_bit(n.ill, illegalInstr);
            if (n.dbgOn) cmp(n.dbg, dbgData);
        end
    end
    initial begin
        #20000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        foreach (mem[i]) mem[i] = FileReset;
        void'($urandom(9));
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        issue(OpIdle, 5'h00);
        // every fourth cell holds zero so the zero flag toggles both ways
        for (int a = 0; a < 32; a++) begin
            issue(OpLit | ((a % 4 == 0) ? 12'h000 : 12'($urandom() & 32'hFF)), 5'h00);
            issue(OpStore | 12'(a), 5'(a));
        end
        for (int a = 0; a < 32; a++) issue(OpIdle, 5'(a));
        $display("test store done");
        for (int a = 0; a < 32; a++) begin
            issue(OpMove | 12'(($urandom() & 32'h1) << 5) | 12'(a), 5'($urandom()));
            issue(OpLit | 12'($urandom() & 32'hFF), 5'h00);
            issue(OpIdle, 5'(a));
        end
        $display("test move done");
        for (int k = 0; k < 8; k++) begin
            issue(OpLit | 12'($urandom() & 32'hFF), 5'h00);
            issue(OpConfig, 5'h00);
        end
        $display("test config done");
        // mid-run reset must return work, config and flags to their reset values; only cell 7 of the file is read back
        @(negedge clk);
        instrValid = 1'b0;
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        w = WorkReset;
        cfg = ConfigReset;
        z = 1'b0;
        foreach (mem[i]) mem[i] = FileReset;
        issue(OpIdle, 5'h07);
        issue(OpConfig, 5'h00);
        $display("test reset done");
        issue(12'h0C5, 5'h05);
        issue(OpIdle, 5'h05);
        $display("test illegal done");
        repeat (3) @(negedge clk);
        report_and_stop();
    end
endmodule
`default_nettype wire
